// File: design/dir_pkg.sv
// shared constants, register map and carrier types for the directory entry writer
package dir_pkg;
  localparam int ENTRY_BYTES = 112;
  localparam int HDR_BYTES = 64;
  localparam int NAME_BYTES = 56;
  localparam int MAX_SLOTS = 255;
  localparam logic [6:0] OFS_START = 7'h38;
  localparam logic [6:0] OFS_BLKCNT = 7'h40;
  localparam logic [6:0] OFS_SIZE = 7'h48;
  localparam logic [6:0] OFS_DATE = 7'h50;
  localparam logic [6:0] OFS_CTIME = 7'h58;
  localparam logic [6:0] OFS_TTYPE = 7'h60;
  localparam logic [6:0] OFS_CLOSE = 7'h68;
  localparam logic [6:0] OFS_LAST = 7'h6F;
  localparam logic [7:0] CH_HYPHEN = 8'h2D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] FILL_FF = 8'hFF;
  localparam logic [7:0] PAD_NUL = 8'h00;
  localparam logic [7:0] TT_UTC = 8'h00;
  localparam logic [7:0] TT_SYS = 8'h01;
  localparam logic [7:0] TT_PKT = 8'hFF;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_START_HI = 8'h08;
  localparam logic [7:0] REG_START_LO = 8'h0C;
  localparam logic [7:0] REG_BCNT_HI = 8'h10;
  localparam logic [7:0] REG_BCNT_LO = 8'h14;
  localparam logic [7:0] REG_SIZE_HI = 8'h18;
  localparam logic [7:0] REG_SIZE_LO = 8'h1C;
  localparam logic [7:0] REG_DATE = 8'h20;
  localparam logic [7:0] REG_CTIME = 8'h24;
  localparam logic [7:0] REG_CLOSE = 8'h28;
  localparam logic [7:0] REG_QUAL = 8'h2C;
  localparam logic [7:0] REG_DIRPOS = 8'h30;
  localparam int CMD_COMMIT_BIT = 0;
  localparam int CMD_DELETE_BIT = 1;
  localparam int CMD_SLOT_LSB = 8;
  localparam int ERR_OVERLAP = 0;
  localparam int ERR_TYPE = 1;
  localparam int ERR_FULL = 2;
  localparam int ERR_ARG = 3;
  localparam logic [63:0] RST_SIZE = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [31:0] RST_QUAL = 32'h01000000;
  localparam logic [3:0] NAME_FIRST = 4'h1;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic valid;
    logic del;
    logic [7:0] byte_val;
    logic [7:0] block;
    logic [7:0] slot;
    logic [6:0] offset;
  } entry_out_type;

  typedef struct packed {
    logic upd;
    logic [7:0] block;
    logic [15:0] count;
  } dir_count_type;
endpackage

// File: design/dir_name_counter.sv
// default file name generator: decimal counter from one, rendered as name bytes
`timescale 1ns/1ns
module dir_name_counter #(
  parameter int NDIG = 8
) (
  // clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic inc,
  // name byte lookup
  input wire logic [6:0] idx,
  output logic [7:0] name_byte
);
  typedef struct packed {
    logic [NDIG-1:0][3:0] dig;
    logic [7:0] len;
  } state_type;

  localparam state_type RST = '{dig: (NDIG*4)'(dir_pkg::NAME_FIRST), len: 8'h01};

  state_type s_r;
  state_type s_nxt;
  logic carry;

  if (NDIG < 3 || NDIG > dir_pkg::NAME_BYTES) begin : g_chk
    $error("name digit count out of range");
  end

  always_comb begin
    s_nxt = s_r;
    carry = inc;
    for (int i = 0; i < NDIG; i++) begin
      if (carry) begin
        if (s_r.dig[i] == 4'h9) begin
          s_nxt.dig[i] = 4'h0;
        end else begin
          s_nxt.dig[i] = s_r.dig[i] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    for (int i = 0; i < NDIG; i++) begin
      if (s_nxt.dig[i] != 4'h0) begin
        s_nxt.len = 8'(i + 1);
      end
    end
  end

  // most significant digit first, zero bytes behind the number
  always_comb begin
    name_byte = dir_pkg::PAD_NUL;
    for (int i = 0; i < NDIG; i++) begin
      if ({1'b0, idx} + 8'(i) + 8'h01 == s_r.len) begin
        name_byte = dir_pkg::CH_ZERO + {4'h0, s_r.dig[i]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
endmodule // dir_name_counter

// File: design/dir_region_table.sv
// table of reserved block ranges, flags any range that would overlap a live one
`timescale 1ns/1ns
module dir_region_table #(
  parameter int DEPTH = 16
) (
  // clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // record and release
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [63:0] wr_start,
  input wire logic [63:0] wr_cnt,
  input wire logic clr_en,
  input wire logic [7:0] clr_idx,
  // query
  input wire logic [63:0] q_start,
  input wire logic [63:0] q_cnt,
  output logic hit_r
);
  typedef struct packed {
    logic [63:0] start;
    logic [63:0] cnt;
  } region_type;

  typedef struct packed {
    region_type [DEPTH-1:0] ent;
    logic hit;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  if (DEPTH < 1 || DEPTH > dir_pkg::MAX_SLOTS) begin : g_chk
    $error("region table depth out of range");
  end

  // 65-bit ends so a range touching the top of the address space still compares
  always_comb begin
    s_nxt = s_r;
    s_nxt.hit = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (s_r.ent[i].cnt != 64'h0 &&
          {1'b0, q_start} < {1'b0, s_r.ent[i].start} + {1'b0, s_r.ent[i].cnt} &&
          {1'b0, s_r.ent[i].start} < {1'b0, q_start} + {1'b0, q_cnt}) begin
        s_nxt.hit = 1'b1;
      end
    end
    if (wr_en) begin
      s_nxt.ent[wr_idx] = '{start: wr_start, cnt: wr_cnt};
    end
    if (clr_en) begin
      s_nxt.ent[clr_idx].cnt = 64'h0;
    end
  end

  assign hit_r = s_r.hit;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
endmodule // dir_region_table

// File: design/dir_entry_writer.sv
// directory entry writer: builds fixed-layout file entries and streams them byte by byte
`timescale 1ns/1ns
module dir_entry_writer #(
  parameter int DIR_BLOCK_BYTES = 512,
  parameter int MAX_ENTRIES = 16,
  parameter int NAME_DIGITS = 8
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire dir_pkg::bus_req_type bus_req,
  output logic [31:0] rdata_r,
  // directory byte stream and entry count
  output dir_pkg::entry_out_type entry_out_r,
  output dir_pkg::dir_count_type dir_count_r
);
  localparam int EPB = (DIR_BLOCK_BYTES - dir_pkg::HDR_BYTES) / dir_pkg::ENTRY_BYTES;

  if (EPB < 1 || MAX_ENTRIES < 1 || MAX_ENTRIES > dir_pkg::MAX_SLOTS) begin : g_chk
    $error("directory geometry out of range");
  end

  typedef enum logic [1:0] {IDLE, CHECK, EVAL, EMIT} st_type;

  typedef struct packed {
    st_type st;
    logic [6:0] ofs;
    logic del;
    logic [7:0] used;
    logic [7:0] blk;
    logic [7:0] inblk;
    logic [7:0] eblk;
    logic [7:0] eslot;
    logic [63:0] start;
    logic [63:0] bcnt;
    logic [63:0] fsize;
    logic [31:0] date;
    logic [31:0] ctime;
    logic [31:0] close;
    logic [31:0] qual;
    logic [3:0] err;
    logic [31:0] rdata;
    dir_pkg::entry_out_type out;
    dir_pkg::dir_count_type cnt;
  } state_type;

  localparam state_type RST = '{
    st: IDLE, ofs: 7'h00, del: 1'b0, used: 8'h00, blk: 8'h00, inblk: 8'h00,
    eblk: 8'h00, eslot: 8'h00, start: 64'h0, bcnt: 64'h0,
    fsize: dir_pkg::RST_SIZE, date: 32'h0, ctime: 32'h0, close: 32'h0,
    qual: dir_pkg::RST_QUAL, err: 4'h0, rdata: 32'h0, out: '0, cnt: '0};

  state_type s_r;
  state_type s_nxt;
  logic [7:0] cur_byte;
  logic [7:0] name_byte;
  logic [7:0] ttype;
  logic [7:0] del_idx;
  logic last;
  logic tbl_wr;
  logic tbl_clr;
  logic hit;
  logic cmd_wr;

  // one digit character, hyphen when marked unknown or not a decimal digit
  function automatic logic [7:0] digit_char(input logic [31:0] digits, input logic [7:0] ok,
                                            input logic [2:0] idx);
    logic [3:0] d;
    d = digits[(7 - idx) * 4 +: 4];
    if (ok[7 - idx] && d <= 4'h9) begin
      return dir_pkg::CH_ZERO + {4'h0, d};
    end
    return dir_pkg::CH_HYPHEN;
  endfunction

  // directory words leave most significant byte first; never the packet-side order
  function automatic logic [7:0] be_byte(input logic [63:0] v, input logic [2:0] idx);
    return v[(7 - idx) * 8 +: 8];
  endfunction

  function automatic logic type_ok(input logic [7:0] t);
    return t == dir_pkg::TT_UTC || t == dir_pkg::TT_SYS || t == dir_pkg::TT_PKT;
  endfunction

  assign ttype = s_r.qual[31:24];
  assign del_idx = bus_req.wdata[dir_pkg::CMD_SLOT_LSB +: 8];
  assign cmd_wr = bus_req.wr && bus_req.addr == dir_pkg::REG_CMD && s_r.st == IDLE;
  assign last = s_r.st == EMIT && s_r.ofs == (s_r.del ? dir_pkg::OFS_SIZE - 7'h01 : dir_pkg::OFS_LAST);
  assign tbl_wr = last && !s_r.del;
  assign tbl_clr = cmd_wr && bus_req.wdata[dir_pkg::CMD_DELETE_BIT] &&
                   !bus_req.wdata[dir_pkg::CMD_COMMIT_BIT] && del_idx < s_r.used;

  dir_name_counter #(
    .NDIG(NAME_DIGITS)
  ) u_name (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .inc(tbl_wr),
    .idx(s_r.ofs),
    .name_byte(name_byte)
  );

  dir_region_table #(
    .DEPTH(MAX_ENTRIES)
  ) u_table (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .wr_en(tbl_wr),
    .wr_idx(s_r.used),
    .wr_start(s_r.start),
    .wr_cnt(s_r.bcnt),
    .clr_en(tbl_clr),
    .clr_idx(del_idx),
    .q_start(s_r.start),
    .q_cnt(s_r.bcnt),
    .hit_r(hit)
  );

  // entry layout: fields in fixed order, each range starts where the last one ends
  always_comb begin
    cur_byte = dir_pkg::FILL_FF;
    if (s_r.ofs < dir_pkg::OFS_START) begin
      cur_byte = name_byte;
    end else if (s_r.ofs < dir_pkg::OFS_BLKCNT) begin
      cur_byte = be_byte(s_r.start, s_r.ofs[2:0]);
    end else if (s_r.ofs < dir_pkg::OFS_SIZE) begin
      cur_byte = s_r.del ? dir_pkg::PAD_NUL : be_byte(s_r.bcnt, s_r.ofs[2:0]);
    end else if (s_r.ofs < dir_pkg::OFS_DATE) begin
      cur_byte = be_byte(s_r.fsize, s_r.ofs[2:0]);
    end else if (s_r.ofs < dir_pkg::OFS_CTIME) begin
      cur_byte = digit_char(s_r.date, s_r.qual[7:0], s_r.ofs[2:0]);
    end else if (s_r.ofs < dir_pkg::OFS_TTYPE) begin
      cur_byte = digit_char(s_r.ctime, s_r.qual[15:8], s_r.ofs[2:0]);
    end else if (s_r.ofs == dir_pkg::OFS_TTYPE) begin
      cur_byte = ttype;
    end else if (s_r.ofs < dir_pkg::OFS_CLOSE) begin
      cur_byte = dir_pkg::FILL_FF;
    end else begin
      cur_byte = digit_char(s_r.close, s_r.qual[23:16], s_r.ofs[2:0]);
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h0;
    s_nxt.out = '0;
    s_nxt.cnt.upd = 1'b0;
    // field registers are frozen while an entry is in flight so it cannot tear
    if (bus_req.wr && s_r.st == IDLE) begin
      case (bus_req.addr)
        dir_pkg::REG_START_HI: s_nxt.start[63:32] = bus_req.wdata;
        dir_pkg::REG_START_LO: s_nxt.start[31:0] = bus_req.wdata;
        dir_pkg::REG_BCNT_HI: s_nxt.bcnt[63:32] = bus_req.wdata;
        dir_pkg::REG_BCNT_LO: s_nxt.bcnt[31:0] = bus_req.wdata;
        dir_pkg::REG_SIZE_HI: s_nxt.fsize[63:32] = bus_req.wdata;
        dir_pkg::REG_SIZE_LO: s_nxt.fsize[31:0] = bus_req.wdata;
        dir_pkg::REG_DATE: s_nxt.date = bus_req.wdata;
        dir_pkg::REG_CTIME: s_nxt.ctime = bus_req.wdata;
        dir_pkg::REG_CLOSE: s_nxt.close = bus_req.wdata;
        dir_pkg::REG_QUAL: s_nxt.qual = bus_req.wdata;
        default: ;
      endcase
    end
    if (bus_req.wr && bus_req.addr == dir_pkg::REG_STATUS) begin
      s_nxt.err = s_r.err & ~bus_req.wdata[4:1];
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        dir_pkg::REG_STATUS: s_nxt.rdata = {16'h0, s_r.used, 3'h0, s_r.err, s_r.st != IDLE};
        dir_pkg::REG_START_HI: s_nxt.rdata = s_r.start[63:32];
        dir_pkg::REG_START_LO: s_nxt.rdata = s_r.start[31:0];
        dir_pkg::REG_BCNT_HI: s_nxt.rdata = s_r.bcnt[63:32];
        dir_pkg::REG_BCNT_LO: s_nxt.rdata = s_r.bcnt[31:0];
        dir_pkg::REG_SIZE_HI: s_nxt.rdata = s_r.fsize[63:32];
        dir_pkg::REG_SIZE_LO: s_nxt.rdata = s_r.fsize[31:0];
        dir_pkg::REG_DATE: s_nxt.rdata = s_r.date;
        dir_pkg::REG_CTIME: s_nxt.rdata = s_r.ctime;
        dir_pkg::REG_CLOSE: s_nxt.rdata = s_r.close;
        dir_pkg::REG_QUAL: s_nxt.rdata = s_r.qual;
        dir_pkg::REG_DIRPOS: s_nxt.rdata = {16'h0, s_r.inblk, s_r.blk};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    case (s_r.st)
      IDLE: begin
        if (cmd_wr && bus_req.wdata[dir_pkg::CMD_COMMIT_BIT]) begin
          if (s_r.used == 8'(MAX_ENTRIES)) begin
            s_nxt.err[dir_pkg::ERR_FULL] = 1'b1;
          end else if (!type_ok(ttype)) begin
            s_nxt.err[dir_pkg::ERR_TYPE] = 1'b1;
          end else if (s_r.bcnt == 64'h0) begin
            s_nxt.err[dir_pkg::ERR_ARG] = 1'b1;
          end else begin
            s_nxt.st = CHECK;
          end
        end else if (cmd_wr && bus_req.wdata[dir_pkg::CMD_DELETE_BIT]) begin
          if (tbl_clr) begin
            s_nxt.st = EMIT;
            s_nxt.del = 1'b1;
            s_nxt.ofs = dir_pkg::OFS_BLKCNT;
            s_nxt.eblk = 8'(int'(del_idx) / EPB);
            s_nxt.eslot = 8'(int'(del_idx) % EPB);
          end else begin
            s_nxt.err[dir_pkg::ERR_ARG] = 1'b1;
          end
        end
      end
      CHECK: s_nxt.st = EVAL;
      EVAL: begin
        if (hit) begin
          s_nxt.st = IDLE;
          s_nxt.err[dir_pkg::ERR_OVERLAP] = 1'b1;
        end else begin
          s_nxt.st = EMIT;
          s_nxt.del = 1'b0;
          s_nxt.ofs = 7'h00;
          s_nxt.eblk = s_r.blk;
          s_nxt.eslot = s_r.inblk;
        end
      end
      EMIT: begin
        s_nxt.out = '{valid: 1'b1, del: s_r.del, byte_val: cur_byte, block: s_r.eblk,
                      slot: s_r.eslot, offset: s_r.ofs};
        s_nxt.ofs = s_r.ofs + 7'h01;
        if (last) begin
          s_nxt.st = IDLE;
          if (!s_r.del) begin
            s_nxt.used = s_r.used + 8'h01;
            // deleted entries keep their slot, so the count only ever grows
            s_nxt.cnt = '{upd: 1'b1, block: s_r.blk, count: {8'h00, s_r.inblk} + 16'h0001};
            if (s_r.inblk == 8'(EPB - 1)) begin
              s_nxt.blk = s_r.blk + 8'h01;
              s_nxt.inblk = 8'h00;
            end else begin
              s_nxt.inblk = s_r.inblk + 8'h01;
            end
          end
        end
      end
      default: s_nxt.st = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rdata_r = s_r.rdata;
  assign entry_out_r = s_r.out;
  assign dir_count_r = s_r.cnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);

  sequence seq_entry_start;
    entry_out_r.valid && !entry_out_r.del && entry_out_r.offset == 7'h00;
  endsequence

  sequence seq_entry_end;
    entry_out_r.valid && !entry_out_r.del && entry_out_r.offset == dir_pkg::OFS_LAST;
  endsequence

  sequence seq_delete_start;
    entry_out_r.valid && entry_out_r.del && entry_out_r.offset == dir_pkg::OFS_BLKCNT;
  endsequence

  a_entry_length: assert property (seq_entry_start |-> ##111 seq_entry_end)
    else $error("entry stream is not exactly one entry long");

  a_reserved_fill: assert property (entry_out_r.valid && entry_out_r.offset > dir_pkg::OFS_TTYPE &&
      entry_out_r.offset < dir_pkg::OFS_CLOSE |-> entry_out_r.byte_val == dir_pkg::FILL_FF)
    else $error("reserved byte not all-ones");

  a_qualifier_code: assert property (entry_out_r.valid && !entry_out_r.del &&
      entry_out_r.offset == dir_pkg::OFS_TTYPE |-> type_ok(entry_out_r.byte_val))
    else $error("reserved time qualifier written");

  a_digit_chars: assert property (entry_out_r.valid && entry_out_r.offset >= dir_pkg::OFS_DATE &&
      entry_out_r.offset != dir_pkg::OFS_TTYPE && !(entry_out_r.offset > dir_pkg::OFS_TTYPE &&
      entry_out_r.offset < dir_pkg::OFS_CLOSE) |->
      entry_out_r.byte_val inside {[8'h30:8'h39], 8'h2D})
    else $error("date or time byte is not a digit or hyphen");

  a_name_padding: assert property (entry_out_r.valid && entry_out_r.offset < 7'h37 &&
      entry_out_r.byte_val == dir_pkg::PAD_NUL |=> entry_out_r.byte_val == dir_pkg::PAD_NUL)
    else $error("name character after padding");

  a_delete_zero: assert property (seq_delete_start |->
      (entry_out_r.valid && entry_out_r.del && entry_out_r.byte_val == 8'h00)[*8] ##1 !entry_out_r.valid)
    else $error("delete did not write eight zero count bytes");

  a_count_step: assert property (seq_entry_end |-> dir_count_r.upd &&
      dir_count_r.block == entry_out_r.block &&
      dir_count_r.count == {8'h00, entry_out_r.slot} + 16'h0001)
    else $error("block entry count does not follow slot");

  a_commit_check: assert property (cmd_wr && bus_req.wdata[dir_pkg::CMD_COMMIT_BIT] &&
      s_r.used != 8'(MAX_ENTRIES) && type_ok(ttype) && s_r.bcnt != 64'h0 |-> ##2 s_r.st == EVAL)
    else $error("accepted commit skipped the overlap check");

  a_field_freeze: assert property (s_r.st != IDLE && bus_req.wr |=> $stable(s_r.date) && $stable(s_r.qual))
    else $error("entry field changed while an entry was in flight");

  a_unknown_hyphen: assert property (entry_out_r.valid && !entry_out_r.del && entry_out_r.offset >= dir_pkg::OFS_CTIME &&
      entry_out_r.offset < dir_pkg::OFS_TTYPE && !s_r.qual[15 - int'(entry_out_r.offset[2:0])] |->
      entry_out_r.byte_val == dir_pkg::CH_HYPHEN)
    else $error("unknown time digit not written as hyphen");

  a_overlap_refuse: assert property (s_r.st == EVAL && hit |=>
      s_r.st == IDLE && s_r.err[dir_pkg::ERR_OVERLAP] ##1 !entry_out_r.valid)
    else $error("overlapping entry was not refused");
endmodule // dir_entry_writer

// File: dv/dir_media_image.sv
// host side media image: collects streamed directory entry bytes and block entry counts
`timescale 1ns/1ns
module dir_media_image #(
  parameter int BLOCK_BYTES = 288
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // directory stream from the writer
  input wire dir_pkg::entry_out_type entry_out,
  input wire dir_pkg::dir_count_type dir_count
);
  logic [7:0] img [0:2*BLOCK_BYTES-1];
  logic [15:0] cnt [0:1];
  int run;
  int burst_len;
  // unwritten media is a pattern, never trusted as data
  initial begin
    foreach (img[i]) img[i] = 8'hA5;
    cnt[0] = 16'h0000;
    cnt[1] = 16'h0000;
    run = 0;
    burst_len = 0;
  end
  // byte k of an entry lands at entry base + k, most significant byte first
  always @(posedge ref_clk) begin
    if (rst) begin
      run <= 0;
    end else if (entry_out.valid) begin
      img[int'(entry_out.block) * BLOCK_BYTES + 64 + 112 * int'(entry_out.slot) + int'(entry_out.offset)] <=
        entry_out.byte_val;
      run <= run + 1;
    end else if (run != 0) begin
      burst_len <= run;
      run <= 0;
    end
    if (!rst && dir_count.upd) begin
      cnt[dir_count.block[0]] <= dir_count.count;
    end
  end
endmodule // dir_media_image

// File: dv/recorder_directory_entry_writer_tb_top.sv
// self-checking bench for the directory entry writer
`timescale 1ns/1ns
module recorder_directory_entry_writer_tb_top;
  logic ref_clk;
  logic rst;
  logic ce;
  dir_pkg::bus_req_type bus_req;
  logic [31:0] rdata_r;
  dir_pkg::entry_out_type entry_out;
  dir_pkg::dir_count_type dir_count;
  int error_cnt;
  int cmp_count;
  logic [31:0] d;

  dir_entry_writer #(.DIR_BLOCK_BYTES(288), .MAX_ENTRIES(4), .NAME_DIGITS(8)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .bus_req(bus_req), .rdata_r(rdata_r),
    .entry_out_r(entry_out), .dir_count_r(dir_count));
  dir_media_image #(.BLOCK_BYTES(288)) model_u (
    .ref_clk(ref_clk), .rst(rst), .entry_out(entry_out), .dir_count(dir_count));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 v = rdata_r;
  endtask

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    chk(what, {32'h0, exp}, {32'h0, d});
  endtask

  // polling keeps the wait bounded even if busy never drops
  task wait_idle;
    logic [31:0] s;
    for (int i = 0; i < 200; i++) begin
      rd(dir_pkg::REG_STATUS, s);
      if (s[0] === 1'b0) return;
    end
    error_cnt++;
    $display("ERROR busy expected 0 seen 1");
    summarize();
  endtask

  task commit(input logic [31:0] start, input logic [31:0] bcnt, input logic [7:0] q);
    wr(dir_pkg::REG_START_LO, start);
    wr(dir_pkg::REG_BCNT_LO, bcnt);
    wr(dir_pkg::REG_QUAL, {q, 8'h00, 8'hFC, 8'hFF});
    wr(dir_pkg::REG_CMD, 32'h1);
    wait_idle();
    // the last byte and the count pulse reach the image one edge after busy drops, the burst length one edge later
    repeat (2) @(posedge ref_clk);
  endtask

  // entry field from the media image, byte 0 most significant
  function automatic logic [63:0] fld(int b, int s, int o, int n);
    logic [63:0] v;
    v = '0;
    for (int k = 0; k < n; k++) v = {v[55:0], model_u.img[b * 288 + 64 + 112 * s + o + k]};
    return v;
  endfunction

  task tend(input string name);
    $display("test %s done", name);
  endtask

  logic [7:0] qs [2] = '{dir_pkg::TT_SYS, dir_pkg::TT_PKT};
  logic [31:0] bad [4][4] = '{'{32'h13, 32'h1, 32'h00, 32'h0302}, '{32'h05, 32'h1, 32'h02, 32'h0304},
    '{32'h05, 32'h1, 32'hFE, 32'h0304}, '{32'h05, 32'h0, 32'h00, 32'h0310}};

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst = 1'b1;
    ce = 1'b1;
    bus_req = '0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk("qual reset", dir_pkg::REG_QUAL, dir_pkg::RST_QUAL);
    rd_chk("size reset", dir_pkg::REG_SIZE_HI, 32'hFFFFFFFF);
    rd_chk("status reset", dir_pkg::REG_STATUS, 32'h0);
    rd_chk("cmd read", dir_pkg::REG_CMD, 32'h0);
    rd_chk("unmapped read", 8'hFC, 32'h0);
    tend("reset");
    ce <= 1'b0;
    wr(dir_pkg::REG_DATE, 32'h11111111);
    ce <= 1'b1;
    rd_chk("date frozen", dir_pkg::REG_DATE, 32'h0);
    tend("clock enable");
    wr(dir_pkg::REG_DATE, 32'h02092000);
    wr(dir_pkg::REG_CTIME, 32'h12345678);
    wr(dir_pkg::REG_CLOSE, 32'h23595999);
    commit(32'h10, 32'h4, dir_pkg::TT_UTC);
    chk("name head", 64'h3100000000000000, fld(0, 0, 0, 8));
    chk("name tail", 64'h0, fld(0, 0, 48, 8));
    chk("start", 64'h10, fld(0, 0, 56, 8));
    chk("block count", 64'h4, fld(0, 0, 64, 8));
    chk("size", 64'hFFFFFFFFFFFFFFFF, fld(0, 0, 72, 8));
    chk("date", 64'h3032303932303030, fld(0, 0, 80, 8));
    chk("create time", 64'h313233343536_2D2D, fld(0, 0, 88, 8));
    chk("qualifier", 64'h0, fld(0, 0, 96, 1));
    chk("reserved", 64'h00FFFFFFFFFFFFFF, fld(0, 0, 97, 7));
    chk("close time", 64'h2D2D2D2D2D2D2D2D, fld(0, 0, 104, 8));
    chk("burst length", 64'd112, 64'(model_u.burst_len));
    chk("count block0", 64'h1, {48'h0, model_u.cnt[0]});
    tend("first entry");
    for (int i = 0; i < 2; i++) begin
      commit(32'h20 + 32'h10 * i, 32'h1, qs[i]);
      chk("name", 64'h32 + i, fld((i + 1) / 2, (i + 1) % 2, 0, 1));
      chk("qualifier", {56'h0, qs[i]}, fld((i + 1) / 2, (i + 1) % 2, 96, 1));
    end
    chk("count block0", 64'h2, {48'h0, model_u.cnt[0]});
    chk("count block1", 64'h1, {48'h0, model_u.cnt[1]});
    tend("fill order");
    for (int i = 0; i < 4; i++) begin
      commit(bad[i][0], bad[i][1], bad[i][2][7:0]);
      rd_chk("refused status", dir_pkg::REG_STATUS, bad[i][3]);
      wr(dir_pkg::REG_STATUS, 32'h1E);
    end
    chk("count after refusals", 64'h1, {48'h0, model_u.cnt[1]});
    tend("refusals");
    wr(dir_pkg::REG_CMD, 32'h0002);
    repeat (12) @(posedge ref_clk);
    chk("deleted count", 64'h0, fld(0, 0, 64, 8));
    rd_chk("status after delete", dir_pkg::REG_STATUS, 32'h0300);
    chk("count kept", 64'h2, {48'h0, model_u.cnt[0]});
    wr(dir_pkg::REG_CMD, 32'h0702);
    repeat (4) @(posedge ref_clk);
    rd_chk("bad delete", dir_pkg::REG_STATUS, 32'h0310);
    wr(dir_pkg::REG_STATUS, 32'h1E);
    tend("delete");
    commit(32'h10, 32'h4, dir_pkg::TT_SYS);
    chk("reuse name", 64'h34, fld(1, 1, 0, 1));
    chk("reuse start", 64'h10, fld(1, 1, 56, 8));
    chk("count block1", 64'h2, {48'h0, model_u.cnt[1]});
    commit(32'h40, 32'h1, dir_pkg::TT_SYS);
    rd_chk("full status", dir_pkg::REG_STATUS, 32'h0408);
    tend("reuse and full");
    summarize();
  end
endmodule // recorder_directory_entry_writer_tb_top
